// ==== rtl/dsp_serial_port.sv ====
// display channel serial port: sync-clocked transmitter, i2c pin routing, registers
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dsp_serial_port import dsp_pkg::*; (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	// axi4-lite write
	input  wire logic [11:0] i_awaddr,
	input  wire logic        i_awvalid,
	output var  logic        o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output var  logic        o_wready,
	output var  logic [1:0]  o_bresp,
	output var  logic        o_bvalid,
	input  wire logic        i_bready,
	// axi4-lite read
	input  wire logic [11:0] i_araddr,
	input  wire logic        i_arvalid,
	output var  logic        o_arready,
	output var  logic [31:0] o_rdata,
	output var  logic [1:0]  o_rresp,
	output var  logic        o_rvalid,
	input  wire logic        i_rready,
	// pins
	input  wire logic        i_vsync,
	input  wire logic        i_scl_in,
	output var  logic        o_scl_out,
	output var  logic        o_scl_oe,
	input  wire logic        i_sda_in,
	output var  logic        o_sda_out,
	output var  logic        o_sda_oe,
	// i2c engine side
	input  wire logic        i_eng_scl_out,
	input  wire logic        i_eng_scl_oe,
	input  wire logic        i_eng_sda_out,
	input  wire logic        i_eng_sda_oe,
	output var  logic        o_eng_scl_in,
	output var  logic        o_eng_sda_in,
	input  wire logic        i_eng_slave_mode,
	input  wire logic [6:0]  i_eng_rx_addr,
	output var  logic        o_eng_addr_match
);
	// ****************************************
	// declarations
	// ****************************************
	logic       vs_level;
	logic       vs_rise;
	logic       vs_fall;
	logic       scl_level;
	logic       scl_fall;
	logic       sda_level;
	logic       clk_low_set;
	logic       be_set;
	logic       aw_have_q;
	logic       w_have_q;
	logic [9:0] aw_idx_q;
	logic [7:0] wdata_q;
	logic       wstrb0_q;
	logic       awready_q;
	logic       wready_q;
	logic       bvalid_q;
	logic [1:0] bresp_q;
	logic       arready_q;
	logic       rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic       wr_fire;
	logic       wr_en;
	logic       wr_hit;
	logic       rd_hit;
	logic [7:0] rd_val;
	logic [7:0] clr_vec;
	logic [7:0] first_control_register_q;
	logic [7:0] second_control_register_q;
	logic [7:0] latch_q;
	logic [7:0] i2c_ctl_q;
	logic [7:0] i2c_dat_q;
	logic [7:0] adr_a_q;
	logic [7:0] adr_b_q;
	logic       clk_low_flag_q;
	logic       buf_empty_flag_q;
	logic [7:0] shift_q;
	logic [3:0] cnt_q;
	logic       load_pend_q;
	logic       sel;
	logic       ninth;
	logic       tx_bit;
	logic       sda_out_q;
	logic       sda_oe_q;
	logic       scl_out_q;
	logic       scl_oe_q;
	logic       eng_scl_in_q;
	logic       eng_sda_in_q;
	logic       match_q;

	// ****************************************
	// pin synchronisers and scl low detector
	// ****************************************
	dsp_sync3 #(.RST_LVL(1'b0)) u_vs_sync (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_async (i_vsync),
		.o_level (vs_level),
		.o_rise  (vs_rise),
		.o_fall  (vs_fall)
	);

	dsp_sync3 #(.RST_LVL(1'b1)) u_scl_sync (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_async (i_scl_in),
		.o_level (scl_level),
		.o_rise  (),
		.o_fall  (scl_fall)
	);

	dsp_sync3 #(.RST_LVL(1'b1)) u_sda_sync (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_async (i_sda_in),
		.o_level (sda_level),
		.o_rise  (),
		.o_fall  ()
	);

	dsp_low_detect u_low (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_fall  (scl_fall),
		.i_level (scl_level),
		.o_event (clk_low_set)
	);

	// ****************************************
	// axi4-lite write channels
	// ****************************************
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wr_en   = wr_fire && wstrb0_q;

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_idx_q  <= 10'h000;
			wdata_q   <= REG_RST;
			wstrb0_q  <= 1'b0;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (i_awvalid && awready_q) begin
				aw_have_q <= 1'b1;
				awready_q <= 1'b0;
				aw_idx_q  <= i_awaddr[11:2];
			end
			if (i_wvalid && wready_q) begin
				w_have_q <= 1'b1;
				wready_q <= 1'b0;
				wdata_q  <= i_wdata[7:0];
				wstrb0_q <= i_wstrb[0];
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && i_bready) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	always_comb begin
		case (aw_idx_q)
			IDX_FIRST_CONTROL_REGISTER, IDX_SECOND_CONTROL_REGISTER, IDX_LATCH, IDX_FLAGS, IDX_CLEAR,
			IDX_I2C_CTL, IDX_I2C_STAT, IDX_I2C_DAT, IDX_I2C_ADRA, IDX_I2C_ADRB: begin
				wr_hit = 1'b1;
			end
			default: begin
				wr_hit = 1'b0;
			end
		endcase
	end

	assign clr_vec = (wr_en && aw_idx_q == IDX_CLEAR) ? wdata_q : 8'h00;

	// ****************************************
	// software registers
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			first_control_register_q   <= REG_RST;
			second_control_register_q   <= REG_RST;
			i2c_ctl_q <= REG_RST;
			i2c_dat_q <= REG_RST;
			adr_a_q   <= REG_RST;
			adr_b_q   <= REG_RST;
		end else if (wr_en) begin
			case (aw_idx_q)
				IDX_FIRST_CONTROL_REGISTER: begin
					first_control_register_q <= wdata_q;
				end
				IDX_SECOND_CONTROL_REGISTER: begin
					second_control_register_q <= wdata_q;
				end
				IDX_I2C_CTL: begin
					i2c_ctl_q <= wdata_q;
				end
				IDX_I2C_DAT: begin
					i2c_dat_q <= wdata_q;
				end
				IDX_I2C_ADRA: begin
					adr_a_q <= wdata_q;
				end
				IDX_I2C_ADRB: begin
					adr_b_q <= wdata_q;
				end
				default: begin
					first_control_register_q <= first_control_register_q;
				end
			endcase
		end
	end

	// latch buffer keeps power-up content until written
	always_ff @(posedge i_mclk) begin
		if (wr_en && aw_idx_q == IDX_LATCH) begin
			latch_q <= wdata_q;
		end
	end

	// ****************************************
	// event flags, set wins over clear
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			clk_low_flag_q   <= 1'b0;
			buf_empty_flag_q <= 1'b0;
		end else begin
			clk_low_flag_q   <= clk_low_set || (clk_low_flag_q && !clr_vec[FLG_CLK_LOW]);
			buf_empty_flag_q <= be_set || (buf_empty_flag_q && !clr_vec[FLG_BUF_EMPTY]);
		end
	end

	// ****************************************
	// axi4-lite read channel
	// ****************************************
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 8'h00;
		case (i_araddr[11:2])
			IDX_FIRST_CONTROL_REGISTER:    rd_val = first_control_register_q;
			IDX_SECOND_CONTROL_REGISTER:    rd_val = second_control_register_q;
			IDX_LATCH:    rd_val = latch_q;
			IDX_FLAGS:    rd_val = {5'h00, buf_empty_flag_q, 1'b0, clk_low_flag_q};
			IDX_CLEAR:    rd_val = 8'h00;
			IDX_I2C_CTL:  rd_val = i2c_ctl_q;
			IDX_I2C_STAT: rd_val = STAT_IDLE;
			IDX_I2C_DAT:  rd_val = i2c_dat_q;
			IDX_I2C_ADRA: rd_val = adr_a_q;
			IDX_I2C_ADRB: rd_val = adr_b_q;
			default:      rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
		end else begin
			if (i_arvalid && arready_q) begin
				arready_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rdata_q   <= {24'h00_0000, rd_val};
				rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (rvalid_q && i_rready) begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// sync-clocked transmitter
	// ****************************************
	assign sel   = first_control_register_q[PORT_SEL_BIT];
	assign ninth = second_control_register_q[NINTH_SEL_BIT];

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			shift_q     <= SHIFT_RST;
			cnt_q       <= CNT_RST;
			load_pend_q <= 1'b0;
		end else if (sel && vs_rise) begin
			if (cnt_q == CNT_LAST) begin
				shift_q     <= latch_q;
				cnt_q       <= CNT_FIRST;
				load_pend_q <= 1'b1;
			end else begin
				shift_q <= {shift_q[6:0], 1'b1};
				cnt_q   <= cnt_q + 4'h1;
			end
		end else if (vs_fall) begin
			load_pend_q <= 1'b0;
		end
	end

	assign be_set = load_pend_q && vs_fall;
	assign tx_bit = !sel ? 1'b1 : (cnt_q == CNT_LAST) ? ninth : shift_q[7];

	// ****************************************
	// pin routing
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			sda_out_q    <= 1'b1;
			sda_oe_q     <= 1'b0;
			scl_out_q    <= 1'b1;
			scl_oe_q     <= 1'b0;
			eng_scl_in_q <= 1'b1;
			eng_sda_in_q <= 1'b1;
		end else if (sel) begin
			sda_out_q    <= tx_bit;
			sda_oe_q     <= 1'b1;
			scl_out_q    <= 1'b1;
			scl_oe_q     <= 1'b0;
			eng_scl_in_q <= 1'b1;
			eng_sda_in_q <= 1'b1;
		end else begin
			sda_out_q    <= i_eng_sda_out;
			sda_oe_q     <= i_eng_sda_oe;
			scl_out_q    <= i_eng_scl_out;
			scl_oe_q     <= i_eng_scl_oe;
			eng_scl_in_q <= scl_level;
			eng_sda_in_q <= sda_level;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			match_q <= 1'b0;
		end else begin
			match_q <= i_eng_slave_mode && ((i_eng_rx_addr == adr_a_q[7:1]) ||
				(i_eng_rx_addr == adr_b_q[7:1]));
		end
	end

	assign o_awready        = awready_q;
	assign o_wready         = wready_q;
	assign o_bvalid         = bvalid_q;
	assign o_bresp          = bresp_q;
	assign o_arready        = arready_q;
	assign o_rvalid         = rvalid_q;
	assign o_rdata          = rdata_q;
	assign o_rresp          = rresp_q;
	assign o_sda_out        = sda_out_q;
	assign o_sda_oe         = sda_oe_q;
	assign o_scl_out        = scl_out_q;
	assign o_scl_oe         = scl_oe_q;
	assign o_eng_scl_in     = eng_scl_in_q;
	assign o_eng_sda_in     = eng_sda_in_q;
	assign o_eng_addr_match = match_q;

	// ****************************************
	// checks
	// ****************************************
	chk_ddc_drive: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		sel && vs_level |=> o_sda_oe && !o_scl_oe)
		else $error("transmit mode does not drive sda");

	chk_i2c_route: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!sel |=> o_sda_out == $past(i_eng_sda_out) && o_scl_oe == $past(i_eng_scl_oe))
		else $error("i2c pins not routed to engine");

	chk_tx_freeze: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!sel |=> $stable(shift_q) && $stable(cnt_q))
		else $error("shifter moved while port disabled");

	chk_ninth_bit: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		sel && cnt_q == CNT_LAST |=> o_sda_out == $past(ninth))
		else $error("ninth bit wrong");

	chk_shift_reset: assert property (@(posedge i_mclk)
		!i_rstn |=> shift_q == SHIFT_RST && cnt_q == CNT_RST)
		else $error("shifter not cleared by reset");

	chk_cnt_range: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		cnt_q <= CNT_LAST)
		else $error("bit counter beyond nine");

	chk_byte_load: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		sel && vs_rise && cnt_q == CNT_LAST |=> cnt_q == CNT_FIRST && shift_q == $past(latch_q))
		else $error("latch not loaded after ninth bit");

	chk_irq_fall: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		load_pend_q && vs_fall |=> buf_empty_flag_q)
		else $error("buffer-empty flag not raised on sync fall");

	chk_be_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		clr_vec[FLG_BUF_EMPTY] && !be_set |=> !buf_empty_flag_q)
		else $error("buffer-empty flag not cleared");

	chk_cl_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		clr_vec[FLG_CLK_LOW] && !clk_low_set |=> !clk_low_flag_q)
		else $error("clock-low flag not cleared");

	chk_addr_master: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		!i_eng_slave_mode |=> !o_eng_addr_match)
		else $error("address match outside slave mode");
endmodule
`default_nettype wire

// ==== rtl/dsp_pkg.sv ====
// constants for the display channel serial port
//
// Notes on behaviour
// - port select 1: vertical sync clocks the shifter, data driven out on SDA
// - port select 0: SCL and SDA pass through to the I2C engine
// - SCL falling then low for 16 clocks raises the clock-low event
// - each sync rise shifts one bit: eight data MSB first, then a ninth
// - after the ninth bit the latch byte loads and buffer-empty is raised
// - port select 0 freezes the shifter and holds its output high
// - ninth bit is 1 when ninth select, bit 4 of second control, is set
// - the shift register clears to zero on every reset
// - the latch buffer has no reset; stale content goes out unwritten
// - bit counter resets to 0, then cycles 1 to 9 per sync clock
// - first bit is presented unclocked, so first nine clocks are invalid
// - a byte written after reset loads at clock 10 and shows from clock 10
// - byte start: load latch, send bit 7, count 1; flag on sync fall
// - slave address matches upper seven bits of either own-address register
// - writing 1 to clear bit 2 drops the buffer-empty flag
// - writing 1 to clear bit 0 drops the clock-low flag
`default_nettype none
package dsp_pkg;
	// ****************************************
	// register indices, byte address is four times the index
	// ****************************************
	localparam logic [9:0] IDX_FIRST_CONTROL_REGISTER    = 10'h010;
	localparam logic [9:0] IDX_SECOND_CONTROL_REGISTER    = 10'h011;
	localparam logic [9:0] IDX_LATCH    = 10'h012;
	localparam logic [9:0] IDX_FLAGS    = 10'h013;
	localparam logic [9:0] IDX_CLEAR    = 10'h014;
	localparam logic [9:0] IDX_I2C_CTL  = 10'h0d8;
	localparam logic [9:0] IDX_I2C_STAT = 10'h0d9;
	localparam logic [9:0] IDX_I2C_DAT  = 10'h0da;
	localparam logic [9:0] IDX_I2C_ADRA = 10'h0db;
	localparam logic [9:0] IDX_I2C_ADRB = 10'h0dc;
	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int         PORT_SEL_BIT  = 3;
	localparam int         NINTH_SEL_BIT = 4;
	localparam int         FLG_CLK_LOW   = 0;
	localparam int         FLG_BUF_EMPTY = 2;
	localparam logic [7:0] REG_RST       = 8'h00;
	localparam logic [7:0] SHIFT_RST     = 8'h00;
	localparam logic [7:0] STAT_IDLE     = 8'hf8;
	localparam logic [3:0] CNT_RST       = 4'h0;
	localparam logic [3:0] CNT_FIRST     = 4'h1;
	localparam logic [3:0] CNT_LAST      = 4'h9;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
	// ****************************************
	// timing: clock-low time in oscillator periods, one period per clock
	// ****************************************
	localparam int         CLK_LOW_PERIODS = 16;
	localparam int         CLK_LOW_CYCLES  = CLK_LOW_PERIODS * 1;
	localparam logic [4:0] LOW_LAST        = 5'(CLK_LOW_CYCLES - 1);
	localparam logic [4:0] LOW_NEED        = 5'(CLK_LOW_CYCLES);
endpackage
`default_nettype wire

// ==== rtl/dsp_sync3.sv ====
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module dsp_sync3 import dsp_pkg::*; #(
	parameter logic RST_LVL = 1'b0
) (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rstn,
	// pin side
	input  wire logic i_async,
	// synchronised side
	output var  logic o_level,
	output var  logic o_rise,
	output var  logic o_fall
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;
	logic agree;

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			s1_q    <= RST_LVL;
			s2_q    <= RST_LVL;
			s3_q    <= RST_LVL;
			level_q <= RST_LVL;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (agree) begin
				level_q <= s3_q;
			end
		end
	end

	assign agree   = (s2_q == s3_q);
	assign o_level = level_q;
	assign o_rise  = agree && s3_q && !level_q;
	assign o_fall  = agree && !s3_q && level_q;
endmodule
`default_nettype wire

// ==== rtl/dsp_low_detect.sv ====
// scl held-low detector
`timescale 1ns/1ps
`default_nettype none
module dsp_low_detect import dsp_pkg::*; (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rstn,
	// synchronised scl
	input  wire logic i_fall,
	input  wire logic i_level,
	// one-cycle event
	output var  logic o_event
);
	logic       run_q;
	logic [4:0] cnt_q;
	logic       event_q;
	logic [4:0] low_run_q;

	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			run_q   <= 1'b0;
			cnt_q   <= 5'h00;
			event_q <= 1'b0;
		end else begin
			event_q <= run_q && !i_level && (cnt_q == LOW_LAST);
			if (i_fall) begin
				run_q <= 1'b1;
				cnt_q <= 5'h00;
			end else if (run_q && !i_level && cnt_q != LOW_LAST) begin
				cnt_q <= cnt_q + 5'h01;
			end else begin
				run_q <= 1'b0;
			end
		end
	end

	// consecutive low samples, for checking only
	always_ff @(posedge i_mclk) begin
		if (!i_rstn) begin
			low_run_q <= 5'h00;
		end else if (i_level) begin
			low_run_q <= 5'h00;
		end else if (low_run_q != 5'h1f) begin
			low_run_q <= low_run_q + 5'h01;
		end
	end

	assign o_event = event_q;

	chk_low_event_time: assert property (@(posedge i_mclk) disable iff (!i_rstn)
		o_event |-> low_run_q >= LOW_NEED)
		else $error("clock-low event before scl was low long enough");
endmodule
`default_nettype wire

// ==== bench/dsp_host_model.sv ====
// host-side model: makes the vertical sync clock and samples sda
`timescale 1ns/1ps
`default_nettype none
module dsp_host_model (
	// control from bench
	input  wire logic i_run,
	// pins
	input  wire logic i_sda,
	output var  logic o_vsync,
	// sampled stream
	output var  logic o_bit,
	output var  int   o_nbits
);
	// ****************************************
	// sync clock of 125 ns, still and low between frames
	// ****************************************
	initial begin
		o_vsync = 1'b0;
		o_bit   = 1'b1;
		o_nbits = 0;
		forever begin
			wait (i_run);
			o_vsync = 1'b1;
			#62;
			o_vsync = 1'b0;
			#48;
			o_bit   = i_sda;
			o_nbits = o_nbits + 1;
			#15;
		end
	end
endmodule
`default_nettype wire

// ==== bench/dsp_serial_port_tb.sv ====
// self-checking bench for the display channel serial port
`timescale 1ns/1ps
`default_nettype none
module dsp_serial_port_tb import dsp_pkg::*;;
	logic        i_mclk    = 1'b0;
	logic        i_rstn    = 1'b0;
	logic [11:0] i_awaddr  = 12'h000;
	logic        i_awvalid = 1'b0;
	logic [31:0] i_wdata   = 32'h0;
	logic [3:0]  i_wstrb   = 4'h0;
	logic        i_wvalid  = 1'b0;
	logic        i_bready  = 1'b0;
	logic [11:0] i_araddr  = 12'h000;
	logic        i_arvalid = 1'b0;
	logic        i_rready  = 1'b0;
	logic [3:0]  eng_drv   = 4'h0;
	logic        eng_slave = 1'b0;
	logic [6:0]  eng_rx    = 7'h00;
	logic        scl_ext   = 1'b1;
	logic        sda_ext   = 1'b1;
	logic        run       = 1'b0;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0]  o_bresp, o_rresp;
	logic [31:0] o_rdata;
	logic        o_scl_out, o_scl_oe, o_sda_out, o_sda_oe;
	logic        o_eng_scl_in, o_eng_sda_in, addr_match, vsync, hbit;
	int          nbits;
	wire         scl_wire;
	wire         sda_wire;
	int          miscompares = 0;
	int          tests_run   = 0;
	int          cycles      = 0;
	int          m_cnt       = 0;
	logic [7:0]  m_sh        = 8'h00;
	logic [7:0]  m_flags     = 8'h00;
	logic [7:0]  m_latch, ra, rb;
	logic        m_ninth     = 1'b0;
	logic        m_sel       = 1'b0;
	logic [31:0] d;
	logic [9:0]  rst_idx [9] = '{IDX_FIRST_CONTROL_REGISTER, IDX_SECOND_CONTROL_REGISTER, IDX_FLAGS, IDX_CLEAR, IDX_I2C_CTL,
		IDX_I2C_STAT, IDX_I2C_DAT, IDX_I2C_ADRA, IDX_I2C_ADRB};
	logic [9:0]  rw_idx [5]  = '{IDX_I2C_CTL, IDX_I2C_DAT, IDX_I2C_ADRA, IDX_I2C_ADRB, IDX_LATCH};

	// ****************************************
	// pins with pull-ups, design and partner
	// ****************************************
	assign scl_wire = scl_ext & (o_scl_oe ? o_scl_out : 1'b1);
	assign sda_wire = sda_ext & (o_sda_oe ? o_sda_out : 1'b1);

	dsp_serial_port u_dsp_serial_port (
		.i_mclk(i_mclk), .i_rstn(i_rstn),
		.i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
		.i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
		.o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
		.o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
		.i_vsync(vsync), .i_scl_in(scl_wire), .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe),
		.i_sda_in(sda_wire), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
		.i_eng_scl_out(eng_drv[3]), .i_eng_scl_oe(eng_drv[2]),
		.i_eng_sda_out(eng_drv[1]), .i_eng_sda_oe(eng_drv[0]),
		.o_eng_scl_in(o_eng_scl_in), .o_eng_sda_in(o_eng_sda_in),
		.i_eng_slave_mode(eng_slave), .i_eng_rx_addr(eng_rx), .o_eng_addr_match(addr_match)
	);

	dsp_host_model u_dsp_host_model (
		.i_run(run), .i_sda(sda_wire), .o_vsync(vsync), .o_bit(hbit), .o_nbits(nbits)
	);

	// ****************************************
	// clock, timeout, checking and bus tasks
	// ****************************************
	initial begin
		forever #4 i_mclk = ~i_mclk;
	end

	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_pin(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask

	function automatic logic [11:0] ba(input logic [9:0] i);
		return {i, 2'b00};
	endfunction

	task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [1:0] er);
		@(posedge i_mclk);
		i_awaddr  <= a;
		i_awvalid <= 1'b1;
		i_wdata   <= dv;
		i_wstrb   <= 4'h1;
		i_wvalid  <= 1'b1;
		i_bready  <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (i_awvalid && o_awready) i_awvalid <= 1'b0;
			if (i_wvalid && o_wready) i_wvalid <= 1'b0;
		end while (!o_bvalid);
		i_bready <= 1'b0;
		chk_word("bresp", 32'(er), 32'(o_bresp));
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge i_mclk);
		i_araddr  <= a;
		i_arvalid <= 1'b1;
		i_rready  <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (i_arvalid && o_arready) i_arvalid <= 1'b0;
		end while (!o_rvalid);
		i_rready <= 1'b0;
		chk_word("rdata", ed, o_rdata);
		chk_word("rresp", 32'(er), 32'(o_rresp));
	endtask

	// ****************************************
	// reference model of the shifter, one step per sync rise
	// ****************************************
	task automatic step(output logic b);
		if (!m_sel) begin
			b = 1'b1;
		end else begin
			if (m_cnt == 9) begin
				m_sh       = m_latch;
				m_cnt      = 1;
				m_flags[2] = 1'b1;
			end else begin
				m_sh  = {m_sh[6:0], 1'b1};
				m_cnt = m_cnt + 1;
			end
			b = (m_cnt == 9) ? m_ninth : m_sh[7];
		end
	endtask

	task automatic frame(input int n);
		logic e;
		@(posedge i_mclk);
		run <= 1'b1;
		repeat (n) begin
			@(nbits);
			step(e);
			chk_pin("sda bit", e, hbit);
		end
		@(posedge i_mclk);
		run <= 1'b0;
		repeat (8) @(posedge i_mclk);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h1b45));
		repeat (5) @(posedge i_mclk);
		i_rstn <= 1'b1;
		foreach (rst_idx[k])
			rd(ba(rst_idx[k]), (rst_idx[k] == IDX_I2C_STAT) ? 32'(STAT_IDLE) : 32'(REG_RST), RESP_OKAY);
		rd(12'hffc, 32'h0, RESP_SLVERR);
		wr(12'hffc, 32'h5a, RESP_SLVERR);
		wr(ba(IDX_I2C_STAT), 32'h0, RESP_OKAY);
		rd(ba(IDX_I2C_STAT), 32'(STAT_IDLE), RESP_OKAY);
		foreach (rw_idx[k]) begin
			d = $urandom;
			wr(ba(rw_idx[k]), d, RESP_OKAY);
			rd(ba(rw_idx[k]), {24'h0, d[7:0]}, RESP_OKAY);
			if (k == 2) ra = d[7:0];
			if (k == 3) rb = d[7:0];
			m_latch = d[7:0];
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge i_mclk);
			eng_slave <= (k != 3);
			eng_rx    <= (k == 1) ? rb[7:1] : (k == 2) ? ~ra[7:1] : ra[7:1];
			repeat (4) @(posedge i_mclk);
			chk_pin("addr match", (k != 3) && (eng_rx == ra[7:1] || eng_rx == rb[7:1]), addr_match);
		end
		repeat (4) begin
			@(posedge i_mclk);
			eng_drv <= 4'($urandom);
			sda_ext <= 1'($urandom);
			repeat (8) @(posedge i_mclk);
			chk_pin("sda out", eng_drv[1], o_sda_out);
			chk_pin("scl out", eng_drv[3], o_scl_out);
			chk_pin("scl to engine", scl_wire, o_eng_scl_in);
			chk_pin("sda oe", eng_drv[0], o_sda_oe);
			chk_pin("scl oe", eng_drv[2], o_scl_oe);
			chk_pin("sda to engine", sda_wire, o_eng_sda_in);
		end
		@(posedge i_mclk);
		eng_drv <= 4'h0;
		sda_ext <= 1'b1;
		repeat (4) @(posedge i_mclk);
		wr(ba(IDX_CLEAR), 32'h5, RESP_OKAY);
		@(posedge i_mclk);
		scl_ext <= 1'b0;
		repeat (14) @(posedge i_mclk);
		scl_ext <= 1'b1;
		rd(ba(IDX_FLAGS), 32'h0, RESP_OKAY);
		@(posedge i_mclk);
		scl_ext <= 1'b0;
		repeat (24) @(posedge i_mclk);
		scl_ext <= 1'b1;
		rd(ba(IDX_FLAGS), 32'h1, RESP_OKAY);
		wr(ba(IDX_CLEAR), 32'h1, RESP_OKAY);
		rd(ba(IDX_FLAGS), 32'h0, RESP_OKAY);
		wr(ba(IDX_SECOND_CONTROL_REGISTER), 32'h1 << NINTH_SEL_BIT, RESP_OKAY);
		m_ninth = 1'b1;
		wr(ba(IDX_FIRST_CONTROL_REGISTER), 32'h1 << PORT_SEL_BIT, RESP_OKAY);
		m_sel = 1'b1;
		frame(9);
		rd(ba(IDX_FLAGS), {24'h0, m_flags}, RESP_OKAY);
		frame(9);
		rd(ba(IDX_FLAGS), {24'h0, m_flags}, RESP_OKAY);
		m_latch = 8'($urandom);
		wr(ba(IDX_LATCH), {24'h0, m_latch}, RESP_OKAY);
		wr(ba(IDX_CLEAR), 32'h4, RESP_OKAY);
		m_flags[2] = 1'b0;
		rd(ba(IDX_FLAGS), {24'h0, m_flags}, RESP_OKAY);
		wr(ba(IDX_SECOND_CONTROL_REGISTER), 32'h0, RESP_OKAY);
		m_ninth = 1'b0;
		frame(9);
		wr(ba(IDX_FIRST_CONTROL_REGISTER), 32'h0, RESP_OKAY);
		m_sel = 1'b0;
		frame(5);
		wr(ba(IDX_FIRST_CONTROL_REGISTER), 32'h1 << PORT_SEL_BIT, RESP_OKAY);
		m_sel = 1'b1;
		frame(9);
		rd(ba(IDX_FLAGS), {24'h0, m_flags}, RESP_OKAY);
		// second reset mid-run: shifter and counter clear, latch keeps its byte
		@(posedge i_mclk);
		i_rstn <= 1'b0;
		repeat (5) @(posedge i_mclk);
		i_rstn <= 1'b1;
		m_cnt   = 0;
		m_sh    = SHIFT_RST;
		m_flags = 8'h00;
		m_ninth = 1'b0;
		m_sel   = 1'b0;
		rd(ba(IDX_FIRST_CONTROL_REGISTER), 32'(REG_RST), RESP_OKAY);
		wr(ba(IDX_FIRST_CONTROL_REGISTER), 32'h1 << PORT_SEL_BIT, RESP_OKAY);
		m_sel = 1'b1;
		frame(18);
		rd(ba(IDX_FLAGS), {24'h0, m_flags}, RESP_OKAY);
		end_of_test();
	end
endmodule
`default_nettype wire
